/* File: lpp_pkg.sv */
package lpp_pkg;
  // Clock and timing figures
  localparam int CLK_NS = 25;
  localparam int IRC_NS = 1000;
  localparam int RETRY_BUS = 2;
  localparam int RETRY_CYC = (IRC_NS + CLK_NS - 1) / CLK_NS + RETRY_BUS;
  localparam int DT_LIMIT_US = 600;
  localparam int DT_LIMIT_CYC = DT_LIMIT_US * 1000 / CLK_NS;
  localparam int OC_MASK_NS = 2000;
  localparam int OC_MASK_CYC = (OC_MASK_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_TIME_NS = 50000;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW = 20;
  localparam int ADDR_W = 5;
  // Register indices, byte address is four times the index
  localparam logic [2:0] IDX_DRIVE = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_TEST_A = 3'h2;
  localparam logic [2:0] IDX_SLEW = 3'h3;
  localparam logic [2:0] IDX_TEST_B = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam logic [2:0] IDX_IRQ_EN = 3'h6;
  localparam logic [2:0] IDX_FLAGS = 3'h7;
  // Field positions
  localparam int DRV_TX_B = 1;
  localparam int DRV_RX_B = 0;
  localparam int CTL_SRC_B = 7;
  localparam int CTL_EN_B = 3;
  localparam int CTL_RXO_B = 2;
  localparam int CTL_WUE_B = 1;
  localparam int CTL_PUE_B = 0;
  localparam int SLW_DIS_B = 7;
  localparam int STS_DT_B = 7;
  localparam int DT_B = 7;
  localparam int OC_B = 6;
  localparam logic [7:0] TEST_RST = 8'h00;
  typedef enum logic [1:0] {
    SLOPE_NORMAL = 2'h0,
    SLOPE_SLOW = 2'h1,
    SLOPE_FAST = 2'h2
  } lpp_slope_e;
  typedef enum logic [1:0] {
    RT_IDLE = 2'h1,
    RT_WAIT = 2'h2
  } lpp_rt_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } lpp_apb_s;
endpackage : lpp_pkg

/* File: lpp_sat_cnt.sv */
`timescale 1ns/1ps
module lpp_sat_cnt
  import lpp_pkg::*;
#(
  parameter logic [CW-1:0] LIMIT = 20'h00001
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  output logic o_done
);
  logic [CW-1:0] cnt;

  // Counts while running, holds at the limit, restarts when idle
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run) begin
      cnt <= '0;
    end else if (cnt != LIMIT) begin
      cnt <= cnt + 20'h00001;
    end
  end

  assign o_done = i_run && (cnt == LIMIT);
endmodule : lpp_sat_cnt

/* File: lpp_retry.sv */
`timescale 1ns/1ps
module lpp_retry
  import lpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  output logic o_fire
);
  localparam logic [7:0] LAST = 8'(RETRY_CYC - 1);
  lpp_rt_e state;
  logic [7:0] cnt;

  // Waits a fixed delay after a failed re-enable, then fires once
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= RT_IDLE;
      cnt <= 8'h00;
    end else begin
      case (state)
        RT_IDLE: begin
          cnt <= 8'h00;
          if (i_start) begin
            state <= RT_WAIT;
          end
        end
        RT_WAIT: begin
          cnt <= cnt + 8'h01;
          if (cnt == LAST) begin
            state <= RT_IDLE;
          end
        end
        default: begin
          state <= RT_IDLE;
        end
      endcase
    end
  end

  assign o_fire = (state == RT_WAIT) && (cnt == LAST);
endmodule : lpp_retry

/* File: lpp_ctrl.sv */
`timescale 1ns/1ps
module lpp_ctrl
  import lpp_pkg::*;
#(
  parameter int DT_LIMIT_CYC_P = DT_LIMIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire lpp_apb_s i_apb,
  input wire logic i_special_mode,
  input wire logic i_sci_txd,
  input wire logic i_bus_rx,
  input wire logic i_overcurrent,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_tx_drive,
  output logic o_tx_enabled,
  output logic [1:0] o_slope_select,
  output logic o_pullup_strong,
  output logic o_rx_out,
  output logic o_irq
);
  localparam int RT_D = RETRY_CYC;
  localparam int RT_E = RETRY_CYC - 1;

  // Register contents
  logic direct_drive_reg, tx_src_sel, phy_enable, receive_only_sel, wake_en, pullup_en, dom_timeout_flag;
  logic [7:0] factory_test_a, factory_test_b;
  logic dom_timeout_disable, stuck_dominant_status, dom_timeout_irq_en, overcurrent_irq_en, overcurrent_flag;
  logic [1:0] slope_select;
  // Protection state
  logic dt_off, oc_off, dt_done, dt_done_q, mask_done, quiet_ok, dt_fire, oc_fire;

  // Bus decode
  logic acc, misalign;
  logic [2:0] idx;
  logic [7:0] wd, rd_mux;

  assign idx = i_apb.paddr[4:2];
  assign misalign = i_apb.paddr[1:0] != 2'h0;
  assign wd = i_apb.pwdata[7:0];
  // A transfer completes at the edge where pready is high
  assign acc = i_apb.psel && i_apb.penable && o_pready;

  // Write accepted this edge to one register index
  function automatic logic wr_to(input logic [2:0] ix);
    wr_to = acc && i_apb.pwrite && !misalign && (idx == ix);
  endfunction : wr_to

  // Transmit input and operating mode
  logic phy_tx_in, tx_dom, normal;
  assign phy_tx_in = tx_src_sel ? direct_drive_reg : i_sci_txd;
  assign tx_dom = !phy_tx_in;
  assign normal = phy_enable && !receive_only_sel;

  // Fault events and clears
  logic dt_hit, oc_hit, dt_clr, oc_clr, dt_ok, oc_ok;
  assign dt_hit = dt_done && !dt_done_q;
  // Over-current only counts after the masking window from the falling edge
  assign oc_hit = i_overcurrent && normal && tx_dom && mask_done && !oc_off;
  // A clear acts only on a flag that is set
  assign dt_clr = wr_to(IDX_FLAGS) && wd[DT_B] && dom_timeout_flag;
  assign oc_clr = wr_to(IDX_FLAGS) && wd[OC_B] && overcurrent_flag;
  assign dt_ok = !stuck_dominant_status && quiet_ok;
  assign oc_ok = !i_overcurrent && quiet_ok;

  // Timers: dominant limit, over-current mask, recessive quiet time
  lpp_sat_cnt #(
    .LIMIT(CW'(DT_LIMIT_CYC_P))
  ) u_dt_cnt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(normal && tx_dom && !dom_timeout_disable),
    .o_done(dt_done)
  );

  lpp_sat_cnt #(
    .LIMIT(CW'(OC_MASK_CYC))
  ) u_oc_mask (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(normal && tx_dom),
    .o_done(mask_done)
  );

  lpp_sat_cnt #(
    .LIMIT(CW'(BIT_CYC))
  ) u_quiet (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(phy_tx_in || !normal),
    .o_done(quiet_ok)
  );

  // Failed re-enable delays, one per fault kind
  lpp_retry u_dt_retry (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(dt_clr && !dt_ok),
    .o_fire(dt_fire)
  );

  lpp_retry u_oc_retry (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(oc_clr && !oc_ok),
    .o_fire(oc_fire)
  );

  // APB answer: one wait state, data and error with pready
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready <= 1'h0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'h0;
    end else begin
      o_pready <= i_apb.psel && i_apb.penable && !o_pready;
      if (i_apb.psel && i_apb.penable && !o_pready) begin
        o_prdata <= misalign ? 32'h00000000 : {24'h000000, rd_mux};
        o_pslverr <= misalign;
      end
    end
  end

  // Read multiplexer; the status register has no write path
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      IDX_DRIVE: begin
        rd_mux[DRV_TX_B] = direct_drive_reg;
        rd_mux[DRV_RX_B] = o_rx_out;
      end
      IDX_CTRL: begin
        rd_mux[CTL_SRC_B] = tx_src_sel;
        rd_mux[CTL_EN_B] = phy_enable;
        rd_mux[CTL_RXO_B] = receive_only_sel;
        rd_mux[CTL_WUE_B] = wake_en;
        rd_mux[CTL_PUE_B] = pullup_en;
      end
      IDX_TEST_A: rd_mux = factory_test_a;
      IDX_SLEW: begin
        rd_mux[SLW_DIS_B] = dom_timeout_disable;
        rd_mux[1:0] = slope_select;
      end
      IDX_TEST_B: rd_mux = factory_test_b;
      IDX_STATUS: rd_mux[STS_DT_B] = stuck_dominant_status;
      IDX_IRQ_EN: begin
        rd_mux[DT_B] = dom_timeout_irq_en;
        rd_mux[OC_B] = overcurrent_irq_en;
      end
      IDX_FLAGS: begin
        rd_mux[DT_B] = dom_timeout_flag;
        rd_mux[OC_B] = overcurrent_flag;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Direct drive and control bits, writable any time
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      direct_drive_reg <= 1'h1;
      tx_src_sel <= 1'h0;
      phy_enable <= 1'h0;
      receive_only_sel <= 1'h0;
      wake_en <= 1'h0;
      pullup_en <= 1'h0;
    end else begin
      if (wr_to(IDX_DRIVE)) begin
        direct_drive_reg <= wd[DRV_TX_B];
      end
      if (wr_to(IDX_CTRL)) begin
        tx_src_sel <= wd[CTL_SRC_B];
        phy_enable <= wd[CTL_EN_B];
        receive_only_sel <= wd[CTL_RXO_B];
        wake_en <= wd[CTL_WUE_B];
        pullup_en <= wd[CTL_PUE_B];
      end
    end
  end

  // Slew setup is frozen while the link is up, so a frame never sees a slope change
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dom_timeout_disable <= 1'h0;
      slope_select <= SLOPE_NORMAL;
    end else if (wr_to(IDX_SLEW) && !phy_enable) begin
      dom_timeout_disable <= wd[SLW_DIS_B];
      slope_select <= wd[1:0];
    end
  end

  // Factory test registers, locked outside special mode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      factory_test_a <= TEST_RST;
      factory_test_b <= TEST_RST;
    end else if (i_special_mode) begin
      if (wr_to(IDX_TEST_A)) begin
        factory_test_a <= wd;
      end
      if (wr_to(IDX_TEST_B)) begin
        factory_test_b <= wd;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dom_timeout_irq_en <= 1'h0;
      overcurrent_irq_en <= 1'h0;
    end else if (wr_to(IDX_IRQ_EN)) begin
      dom_timeout_irq_en <= wd[DT_B];
      overcurrent_irq_en <= wd[OC_B];
    end
  end

  // Stuck-dominant status: set on timeout, dropped once input goes recessive
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stuck_dominant_status <= 1'h0;
      dt_done_q <= 1'h0;
    end else begin
      dt_done_q <= dt_done;
      if (dt_hit) begin
        stuck_dominant_status <= 1'h1;
      end else if (phy_tx_in) begin
        stuck_dominant_status <= 1'h0;
      end
    end
  end

  // Dominant-timeout flag and shut-off; a new event wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dom_timeout_flag <= 1'h0;
      dt_off <= 1'h0;
    end else begin
      if (dt_hit || dt_fire) begin
        dom_timeout_flag <= 1'h1;
      end else if (dt_clr) begin
        dom_timeout_flag <= 1'h0;
      end
      if (dt_hit) begin
        dt_off <= 1'h1;
      end else if (dt_clr && dt_ok) begin
        dt_off <= 1'h0;
      end
    end
  end

  // Over-current flag and shut-off, same retry scheme
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      overcurrent_flag <= 1'h0;
      oc_off <= 1'h0;
    end else begin
      if (oc_hit || oc_fire) begin
        overcurrent_flag <= 1'h1;
      end else if (oc_clr) begin
        overcurrent_flag <= 1'h0;
      end
      if (oc_hit) begin
        oc_off <= 1'h1;
      end else if (oc_clr && oc_ok) begin
        oc_off <= 1'h0;
      end
    end
  end

  // Line-side outputs; analog current limit stays outside this block
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_drive <= 1'h0;
      o_tx_enabled <= 1'h0;
      o_slope_select <= SLOPE_NORMAL;
      o_pullup_strong <= 1'h0;
      o_rx_out <= 1'h1;
      o_irq <= 1'h0;
    end else begin
      o_tx_enabled <= normal && !dt_off && !oc_off;
      o_tx_drive <= normal && !dt_off && !oc_off && tx_dom;
      o_slope_select <= slope_select;
      o_pullup_strong <= phy_enable && pullup_en;
      o_rx_out <= i_bus_rx;
      o_irq <= (dom_timeout_flag && dom_timeout_irq_en) || (overcurrent_flag && overcurrent_irq_en);
    end
  end

  property p_slew_lock;
    @(posedge i_clk) disable iff (i_srst)
      (wr_to(IDX_SLEW) && phy_enable) |=> $stable(slope_select) && $stable(dom_timeout_disable);
  endproperty
  a_slew_lock: assert property (p_slew_lock) else $error("slew changed while enabled");

  property p_dt_disabled;
    @(posedge i_clk) disable iff (i_srst)
      (dom_timeout_disable && !dt_fire && !dt_done_q) |-> !dt_hit ##1 !$rose(dom_timeout_flag);
  endproperty
  a_dt_disabled: assert property (p_dt_disabled) else $error("timeout fired while disabled");

  property p_status_ro;
    @(posedge i_clk) disable iff (i_srst)
      (wr_to(IDX_STATUS) && !dt_hit && !phy_tx_in) |=> $stable(stuck_dominant_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_stuck_drop;
    @(posedge i_clk) disable iff (i_srst)
      (stuck_dominant_status && phy_tx_in) |=> !stuck_dominant_status;
  endproperty
  a_stuck_drop: assert property (p_stuck_drop) else $error("stuck status not dropped");

  property p_irq_dt;
    @(posedge i_clk) disable iff (i_srst)
      (dom_timeout_flag && dom_timeout_irq_en) |=> o_irq;
  endproperty
  a_irq_dt: assert property (p_irq_dt) else $error("timeout interrupt missing");

  property p_irq_oc;
    @(posedge i_clk) disable iff (i_srst)
      (overcurrent_flag && overcurrent_irq_en) |=> o_irq;
  endproperty
  a_irq_oc: assert property (p_irq_oc) else $error("over-current interrupt missing");

  property p_w1c_zero;
    @(posedge i_clk) disable iff (i_srst)
      (wr_to(IDX_FLAGS) && !wd[DT_B] && dom_timeout_flag) |=> dom_timeout_flag;
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared flag");

  property p_dt_shut;
    @(posedge i_clk) disable iff (i_srst)
      dt_hit |=> dom_timeout_flag && dt_off ##1 !o_tx_drive && !o_tx_enabled;
  endproperty
  a_dt_shut: assert property (p_dt_shut) else $error("timeout did not shut transmitter");

  property p_dt_retry;
    @(posedge i_clk) disable iff (i_srst)
      (dt_clr && !dt_ok && !dt_hit) |=> (!dom_timeout_flag && dt_off) [*1] ##RT_E !dom_timeout_flag ##1 dom_timeout_flag;
  endproperty
  a_dt_retry: assert property (p_dt_retry) else $error("timeout retry delay wrong");

  property p_oc_shut;
    @(posedge i_clk) disable iff (i_srst)
      oc_hit |=> overcurrent_flag && oc_off ##1 !o_tx_drive;
  endproperty
  a_oc_shut: assert property (p_oc_shut) else $error("over-current did not shut transmitter");

  property p_oc_retry;
    @(posedge i_clk) disable iff (i_srst)
      (oc_clr && !oc_ok && !oc_hit) |=> ##RT_D overcurrent_flag && oc_off;
  endproperty
  a_oc_retry: assert property (p_oc_retry) else $error("over-current retry delay wrong");

  property p_oc_mask;
    @(posedge i_clk) disable iff (i_srst)
      (!mask_done && !oc_fire && !overcurrent_flag) |=> !overcurrent_flag;
  endproperty
  a_oc_mask: assert property (p_oc_mask) else $error("masked over-current reported");

  property p_receive_only_sel_watch;
    @(posedge i_clk) disable iff (i_srst)
      !normal |-> !dt_done && !mask_done;
  endproperty
  a_receive_only_sel_watch: assert property (p_receive_only_sel_watch) else $error("timeout watched outside normal mode");
endmodule : lpp_ctrl

/* File: lpp_bus_model.sv */
`timescale 1ns/1ps
// Far side of the line: pull-up to recessive plus an optional short to supply
module lpp_bus_model (
  input wire logic i_tx_drive,
  input wire logic i_short,
  output logic o_bus_rx,
  output logic o_overcurrent
);
  // A short to supply holds the line high and loads our driver while it pulls low
  assign o_bus_rx = i_short | !i_tx_drive;
  assign o_overcurrent = i_short & i_tx_drive;
endmodule : lpp_bus_model

/* File: lpp_ctrl_test.sv */
`timescale 1ns/1ps
module lpp_ctrl_test;
  import lpp_pkg::*;
  localparam int DTL = 20;
  localparam int CEIL = 20000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  lpp_apb_s apb = '0;
  logic special = 1'b0;
  logic sci_txd = 1'b1;
  logic short_on = 1'b0;
  logic bus_rx, ovc, tx_drive, tx_en, pu, rx_out, irq, pready, pslverr, rd_err;
  logic [31:0] prdata, rd;
  logic [1:0] slope;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Short timeout limit keeps the run brief
  lpp_ctrl #(.DT_LIMIT_CYC_P(DTL)) dut_u (.i_clk(clk), .i_srst(srst), .i_apb(apb), .i_special_mode(special),
    .i_sci_txd(sci_txd), .i_bus_rx(bus_rx), .i_overcurrent(ovc), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_tx_drive(tx_drive), .o_tx_enabled(tx_en), .o_slope_select(slope),
    .o_pullup_strong(pu), .o_rx_out(rx_out), .o_irq(irq));
  lpp_bus_model bus_u (.i_tx_drive(tx_drive), .i_short(short_on), .o_bus_rx(bus_rx), .o_overcurrent(ovc));

  // Clock
  always #12.5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] addr, input logic [7:0] d);
    @(posedge clk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= addr;
    apb.pwdata <= {24'h000000, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    xfer(1'b1, {idx, 2'b00}, d);
  endtask : wr

  task automatic rdc(input string what, input logic [2:0] idx, input logic [31:0] exp);
    xfer(1'b0, {idx, 2'b00}, 8'h00);
    chk(what, exp, rd);
  endtask : rdc

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++)
      @(negedge clk);
  endtask : wait_irq

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdc("reset value", 3'(i), (i == 0) ? 32'h00000003 : 32'h00000000);
    end
    chk("slope", 32'h0, {30'h0, slope});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int c = 0; c < 3; c++) begin
      wr(IDX_SLEW, 8'(c));
      rdc("slew", IDX_SLEW, 32'(c));
      chk("slope", 32'(c), {30'h0, slope});
    end
    wr(IDX_SLEW, 8'h00);
    wr(IDX_CTRL, 8'h08);
    wr(IDX_SLEW, 8'h82);
    rdc("slew locked", IDX_SLEW, 32'h0);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_SLEW, 8'h82);
    rdc("slew open", IDX_SLEW, 32'h82);
    wr(IDX_SLEW, 8'h00);
    wr(IDX_STATUS, 8'hFF);
    rdc("status", IDX_STATUS, 32'h0);
    wr(IDX_IRQ_EN, 8'hFF);
    rdc("irq enable", IDX_IRQ_EN, 32'hC0);
    wr(IDX_IRQ_EN, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(k ? IDX_TEST_B : IDX_TEST_A, 8'h5A);
      rdc("test locked", k ? IDX_TEST_B : IDX_TEST_A, 32'h0);
      special <= 1'b1;
      wr(k ? IDX_TEST_B : IDX_TEST_A, 8'h5A);
      rdc("test open", k ? IDX_TEST_B : IDX_TEST_A, 32'h5A);
      special <= 1'b0;
    end
    xfer(1'b0, 5'h0D, 8'h00);
    chk("slverr", 32'h1, {31'h0, rd_err});
    $display("t_regs done");
  endtask : t_regs

  task automatic t_timeout();
    wr(IDX_IRQ_EN, 8'h80);
    wr(IDX_CTRL, 8'h89);
    // Pull-up output is registered one edge after the write lands
    repeat (2) @(negedge clk);
    chk("pullup", 32'h1, {31'h0, pu});
    wr(IDX_DRIVE, 8'h00);
    wait_irq(DTL + 40);
    chk("irq", 32'h1, {31'h0, irq});
    @(negedge clk);
    chk("tx enabled", 32'h0, {31'h0, tx_en});
    rdc("flags", IDX_FLAGS, 32'h80);
    rdc("status", IDX_STATUS, 32'h80);
    wr(IDX_FLAGS, 8'h00);
    rdc("flags", IDX_FLAGS, 32'h80);
    wr(IDX_FLAGS, 8'h80);
    rdc("flags", IDX_FLAGS, 32'h0);
    wait_cyc(45);
    rdc("flags", IDX_FLAGS, 32'h80);
    chk("tx enabled", 32'h0, {31'h0, tx_en});
    wr(IDX_DRIVE, 8'h02);
    rdc("status", IDX_STATUS, 32'h0);
    wait_cyc(BIT_CYC + 20);
    wr(IDX_FLAGS, 8'h80);
    wait_cyc(50);
    rdc("flags", IDX_FLAGS, 32'h0);
    chk("tx enabled", 32'h1, {31'h0, tx_en});
    chk("irq", 32'h0, {31'h0, irq});
    $display("t_timeout done");
  endtask : t_timeout

  task automatic t_nowatch();
    wr(IDX_CTRL, 8'h8C);
    wr(IDX_DRIVE, 8'h00);
    wait_cyc(DTL + 40);
    rdc("flags", IDX_FLAGS, 32'h0);
    wr(IDX_CTRL, 8'h80);
    wait_cyc(DTL + 40);
    rdc("flags", IDX_FLAGS, 32'h0);
    wr(IDX_SLEW, 8'h80);
    wr(IDX_CTRL, 8'h88);
    wait_cyc(DTL + 40);
    rdc("flags", IDX_FLAGS, 32'h0);
    chk("tx drive", 32'h1, {31'h0, tx_drive});
    wr(IDX_DRIVE, 8'h02);
    wr(IDX_CTRL, 8'h08);
    @(posedge clk) sci_txd <= 1'b0;
    wait_cyc(5);
    chk("tx drive", 32'h1, {31'h0, tx_drive});
    rdc("receiver", IDX_DRIVE, 32'h02);
    chk("rx out", 32'h0, {31'h0, rx_out});
    @(posedge clk) sci_txd <= 1'b1;
    wait_cyc(5);
    chk("tx drive", 32'h0, {31'h0, tx_drive});
    $display("t_nowatch done");
  endtask : t_nowatch

  task automatic t_overcurrent();
    wr(IDX_IRQ_EN, 8'h40);
    @(posedge clk) short_on <= 1'b1;
    // Short bits stay inside the masking window
    repeat (4) begin
      @(posedge clk) sci_txd <= 1'b0;
      wait_cyc(OC_MASK_CYC / 2);
      @(posedge clk) sci_txd <= 1'b1;
      wait_cyc(OC_MASK_CYC / 2);
    end
    rdc("flags", IDX_FLAGS, 32'h0);
    chk("tx enabled", 32'h1, {31'h0, tx_en});
    @(posedge clk) sci_txd <= 1'b0;
    wait_irq(OC_MASK_CYC + 40);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("flags", IDX_FLAGS, 32'h40);
    chk("tx enabled", 32'h0, {31'h0, tx_en});
    wr(IDX_IRQ_EN, 8'h00);
    wait_cyc(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_EN, 8'h40);
    wr(IDX_FLAGS, 8'h40);
    wait_cyc(45);
    rdc("flags", IDX_FLAGS, 32'h40);
    chk("tx enabled", 32'h0, {31'h0, tx_en});
    @(posedge clk) sci_txd <= 1'b1;
    short_on <= 1'b0;
    wait_cyc(BIT_CYC + 20);
    wr(IDX_FLAGS, 8'h40);
    wait_cyc(50);
    rdc("flags", IDX_FLAGS, 32'h0);
    chk("tx enabled", 32'h1, {31'h0, tx_en});
    $display("t_overcurrent done");
  endtask : t_overcurrent

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_timeout();
    t_nowatch();
    t_overcurrent();
    conclude();
  end
endmodule : lpp_ctrl_test
